// ---- core/acr_pkg.sv ----
/*
  acr_pkg: offsets, field positions, reset values and codes shared by the
  channel configuration register bank and its bus slave.
  assumes: an 8-bit register space reached by word index over a 32-bit bus.
*/
package acr_pkg;

  // register indices are word indices, not byte offsets, so byte address = 4 * index
  localparam logic [7:0] ACR_IDX_CH3_GAIN_TRIM = 8'h49;
  localparam logic [7:0] ACR_IDX_CH3_PHASE_TRIM = 8'h4A;
  localparam logic [7:0] ACR_IDX_CH4_INPUT_SETUP = 8'h4B;
  localparam logic [7:0] ACR_IDX_CH4_ANALOG_GAIN = 8'h4C;
  localparam logic [7:0] ACR_IDX_CH4_DIGITAL_VOLUME = 8'h4D;
  // extra register holding the global agc configuration bit that enabled agc follows
  localparam logic [7:0] ACR_IDX_AGC_GLOBAL_CFG = 8'h6C;
  // status register showing the decoded, effective controls
  localparam logic [7:0] ACR_IDX_EFFECT_STATUS = 8'h70;

  // reset values
  localparam logic [7:0] ACR_RST_CH3_GAIN_TRIM = 8'h80;
  localparam logic [7:0] ACR_RST_CH3_PHASE_TRIM = 8'h00;
  localparam logic [7:0] ACR_RST_CH4_INPUT_SETUP = 8'h00;
  localparam logic [7:0] ACR_RST_CH4_ANALOG_GAIN = 8'h00;
  localparam logic [7:0] ACR_RST_CH4_DIGITAL_VOLUME = 8'hC9;
  localparam logic [7:0] ACR_RST_AGC_GLOBAL_CFG = 8'h00;

  // writable-bit masks; zero bits are reserved and read zero
  localparam logic [7:0] ACR_MASK_GAIN_TRIM = 8'hF0;
  localparam logic [7:0] ACR_MASK_PHASE_TRIM = 8'hFF;
  localparam logic [7:0] ACR_MASK_INPUT_SETUP = 8'hFD;
  localparam logic [7:0] ACR_MASK_ANALOG_GAIN = 8'hFC;
  localparam logic [7:0] ACR_MASK_DIGITAL_VOLUME = 8'hFF;
  localparam logic [7:0] ACR_MASK_AGC_GLOBAL = 8'h08;

  // field positions
  localparam int ACR_POS_GAIN_TRIM = 4;
  localparam int ACR_POS_LINE_SEL = 7;
  localparam int ACR_POS_SOURCE = 5;
  localparam int ACR_POS_COUPLING = 4;
  localparam int ACR_POS_IMPEDANCE = 2;
  localparam int ACR_POS_AUTO_GAIN = 0;
  localparam int ACR_POS_CHAN_GAIN = 2;
  localparam int ACR_POS_AGC_GLOBAL = 3;

  // code limits
  localparam logic [3:0] ACR_GAIN_TRIM_ZERO_DB = 4'h8;
  localparam logic [5:0] ACR_CHAN_GAIN_MAX = 6'h2A;
  localparam logic [7:0] ACR_VOLUME_MUTE = 8'h00;

  // input source codes
  typedef enum logic [1:0] {
    ACR_SRC_ANALOG_DIFF = 2'h0,
    ACR_SRC_ANALOG_SE = 2'h1,
    ACR_SRC_PDM = 2'h2,
    ACR_SRC_RESERVED = 2'h3
  } acr_src_t;

  // impedance codes
  localparam logic [1:0] ACR_IMP_RESERVED = 2'h3;

endpackage : acr_pkg

// ---- core/acr_field_reg.sv ----
/*
  acr_field_reg: one 8-bit configuration register with a writable-bit mask.
  assumes: write strobe is one cycle and synchronous to clock.
*/
`timescale 1ns/1ps
module acr_field_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hFF
) (
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic wr_en, // one-cycle write strobe
  input wire logic [7:0] wr_data, // value to store
  output logic [7:0] value_q // stored value, reserved bits zero
);

  typedef struct packed {
    logic [7:0] value;
  } acr_freg_t;

  acr_freg_t state_q;
  acr_freg_t state_d;

  // masked store keeps reserved positions at zero
  always_comb
  begin
    state_d = state_q;
    if (wr_en)
    begin
      state_d.value = wr_data & WRITE_MASK;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q.value <= RESET_VALUE & WRITE_MASK;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign value_q = state_q.value;

endmodule : acr_field_reg

// ---- core/acr_channel_cfg.sv ----
/*
  acr_channel_cfg: channel 3 trim and channel 4 input, gain, volume and
  agc configuration bank behind a classic wishbone slave.
  assumes: single clock domain; the front end, agc engine and volume
  datapath consume the decoded outputs; software configures pin muxing.
*/
// What this block does
// - gain trim field bits 7-4; code 8 is 0 dB, 0.1 dB per step.
// - gain trim resets to 8; its low four bits read zero.
// - phase delay field delays by code modulator cycles, zero none, resets zero.
// - bit 7 selects microphone (0) or line (1) input, resets 0.
// - bits 6-5 pick analog differential, single-ended or pdm; 3 reserved.
// - bit 4 selects ac or dc coupling, only for analog sources.
// - bits 3-2 pick 2.5k, 10k or 20k impedance; 3 reserved.
// - bit 0 enables agc per global config bit 3; bit 1 reads zero.
// - bits 7-2 channel gain 0 to 42 dB; 43-63 reserved.
// - volume mutes at 0, 0 dB at 201, resets to 201.
`timescale 1ns/1ps
module acr_channel_cfg
  import acr_pkg::*;
(
  input wire logic clock, // 100 MHz system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [31:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic wb_err_o, // unmapped address answer
  output logic [3:0] ch3_gain_trim_code, // ch3 gain trim code
  output logic [7:0] ch3_phase_delay_code, // ch3 phase delay in modulator cycles
  output logic ch4_line_select, // ch4 line input when high
  output logic [1:0] ch4_source_select, // ch4 source code as stored
  output logic ch4_analog_active, // ch4 uses an analog source
  output logic ch4_pdm_active, // ch4 uses the pdm source
  output logic coupling_a, // coupling_a coupling, analog only
  output logic [1:0] ch4_impedance_select, // ch4 impedance code as stored
  output logic ch4_impedance_valid, // ch4 impedance code defined and analog
  output logic ch4_auto_gain_on, // ch4 agc effectively running
  output logic [5:0] code_b, // ch4 channel gain, clamped to defined range
  output logic [7:0] ch4_volume_code, // ch4 digital volume code
  output logic ch4_volume_muted // ch4 volume at mute code
);

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic [3:0] trim;
    logic [7:0] phase;
    logic line_sel;
    logic [1:0] src;
    logic an_act;
    logic pdm_act;
    logic dc;
    logic [1:0] imp;
    logic imp_ok;
    logic agc;
    logic [5:0] gain;
    logic [7:0] vol;
    logic muted;
  } acr_state_t;

  acr_state_t state_q;
  acr_state_t state_d;

  logic [7:0] idx;
  logic req;
  logic wr_go;
  logic [7:0] wdata;
  logic [7:0] r_trim;
  logic [7:0] r_phase;
  logic [7:0] r_setup;
  logic [7:0] r_gain;
  logic [7:0] r_vol;
  logic [7:0] r_agc;
  logic [7:0] eff_status;
  logic mapped;
  logic [5:0] wr_sel;

  // word index decode; only the low lane carries data, upper bits read zero
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i && wb_stb_i && !state_q.ack && !state_q.err;
  assign wdata = wb_dat_i[7:0];
  assign wr_go = req && wb_we_i && mapped && wb_sel_i[0];

  always_comb
  begin
    mapped = 1'b1;
    wr_sel = 6'h00;
    case (idx)
      ACR_IDX_CH3_GAIN_TRIM: wr_sel[0] = wr_go;
      ACR_IDX_CH3_PHASE_TRIM: wr_sel[1] = wr_go;
      ACR_IDX_CH4_INPUT_SETUP: wr_sel[2] = wr_go;
      ACR_IDX_CH4_ANALOG_GAIN: wr_sel[3] = wr_go;
      ACR_IDX_CH4_DIGITAL_VOLUME: wr_sel[4] = wr_go;
      ACR_IDX_AGC_GLOBAL_CFG: wr_sel[5] = wr_go;
      ACR_IDX_EFFECT_STATUS: wr_sel = 6'h00;
      default: mapped = 1'b0;
    endcase
  end

  // storage; masks drop reserved bits so they read zero
  acr_field_reg #(.RESET_VALUE(ACR_RST_CH3_GAIN_TRIM), .WRITE_MASK(ACR_MASK_GAIN_TRIM))
    u_trim (.clock(clock), .sys_rst(sys_rst), .wr_en(wr_sel[0]), .wr_data(wdata),
            .value_q(r_trim));
  acr_field_reg #(.RESET_VALUE(ACR_RST_CH3_PHASE_TRIM), .WRITE_MASK(ACR_MASK_PHASE_TRIM))
    u_phase (.clock(clock), .sys_rst(sys_rst), .wr_en(wr_sel[1]), .wr_data(wdata),
             .value_q(r_phase));
  acr_field_reg #(.RESET_VALUE(ACR_RST_CH4_INPUT_SETUP), .WRITE_MASK(ACR_MASK_INPUT_SETUP))
    u_setup (.clock(clock), .sys_rst(sys_rst), .wr_en(wr_sel[2]), .wr_data(wdata),
             .value_q(r_setup));
  acr_field_reg #(.RESET_VALUE(ACR_RST_CH4_ANALOG_GAIN), .WRITE_MASK(ACR_MASK_ANALOG_GAIN))
    u_gain (.clock(clock), .sys_rst(sys_rst), .wr_en(wr_sel[3]), .wr_data(wdata),
            .value_q(r_gain));
  acr_field_reg #(.RESET_VALUE(ACR_RST_CH4_DIGITAL_VOLUME),
                  .WRITE_MASK(ACR_MASK_DIGITAL_VOLUME))
    u_vol (.clock(clock), .sys_rst(sys_rst), .wr_en(wr_sel[4]), .wr_data(wdata),
           .value_q(r_vol));
  acr_field_reg #(.RESET_VALUE(ACR_RST_AGC_GLOBAL_CFG), .WRITE_MASK(ACR_MASK_AGC_GLOBAL))
    u_agc (.clock(clock), .sys_rst(sys_rst), .wr_en(wr_sel[5]), .wr_data(wdata),
           .value_q(r_agc));

  // effective controls as seen by downstream logic, readable for debug
  assign eff_status = {state_q.muted, state_q.agc, state_q.imp_ok, state_q.dc,
                       state_q.pdm_act, state_q.an_act, 2'h0};

  // decode, bus answer and output registering
  always_comb
  begin
    logic [1:0] src;
    logic analog;
    logic [5:0] gain_code;
    src = r_setup[ACR_POS_SOURCE +: 2];
    analog = (src == ACR_SRC_ANALOG_DIFF) || (src == ACR_SRC_ANALOG_SE);
    gain_code = r_gain[ACR_POS_CHAN_GAIN +: 6];
    state_d = state_q;
    state_d.trim = r_trim[ACR_POS_GAIN_TRIM +: 4];
    state_d.phase = r_phase;
    state_d.line_sel = r_setup[ACR_POS_LINE_SEL];
    state_d.src = src;
    state_d.an_act = analog;
    state_d.pdm_act = (src == ACR_SRC_PDM);
    // coupling and impedance only mean something for an analog source
    state_d.dc = analog && r_setup[ACR_POS_COUPLING];
    state_d.imp = r_setup[ACR_POS_IMPEDANCE +: 2];
    state_d.imp_ok = analog && (r_setup[ACR_POS_IMPEDANCE +: 2] != ACR_IMP_RESERVED);
    // agc runs only when both the channel enable and global bit are set
    state_d.agc = r_setup[ACR_POS_AUTO_GAIN] && r_agc[ACR_POS_AGC_GLOBAL];
    // reserved gain codes held at the top defined step, never beyond 42 dB
    state_d.gain = (gain_code > ACR_CHAN_GAIN_MAX) ? ACR_CHAN_GAIN_MAX : gain_code;
    state_d.vol = r_vol;
    state_d.muted = (r_vol == ACR_VOLUME_MUTE);
    // ack for one cycle; the master must drop stb before the next request
    state_d.ack = req && mapped;
    state_d.err = req && !mapped;
    state_d.rdata = 32'h0000_0000;
    if (req && !wb_we_i)
    begin
      case (idx)
        ACR_IDX_CH3_GAIN_TRIM: state_d.rdata[7:0] = r_trim;
        ACR_IDX_CH3_PHASE_TRIM: state_d.rdata[7:0] = r_phase;
        ACR_IDX_CH4_INPUT_SETUP: state_d.rdata[7:0] = r_setup;
        ACR_IDX_CH4_ANALOG_GAIN: state_d.rdata[7:0] = r_gain;
        ACR_IDX_CH4_DIGITAL_VOLUME: state_d.rdata[7:0] = r_vol;
        ACR_IDX_AGC_GLOBAL_CFG: state_d.rdata[7:0] = r_agc;
        ACR_IDX_EFFECT_STATUS: state_d.rdata[7:0] = eff_status;
        default: state_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q <= '0;
      state_q.trim <= ACR_GAIN_TRIM_ZERO_DB;
      state_q.vol <= ACR_RST_CH4_DIGITAL_VOLUME;
      state_q.an_act <= 1'b1;
      state_q.imp_ok <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign wb_ack_o = state_q.ack;
  assign wb_err_o = state_q.err;
  assign wb_dat_o = state_q.rdata;
  assign ch3_gain_trim_code = state_q.trim;
  assign ch3_phase_delay_code = state_q.phase;
  assign ch4_line_select = state_q.line_sel;
  assign ch4_source_select = state_q.src;
  assign ch4_analog_active = state_q.an_act;
  assign ch4_pdm_active = state_q.pdm_act;
  assign coupling_a = state_q.dc;
  assign ch4_impedance_select = state_q.imp;
  assign ch4_impedance_valid = state_q.imp_ok;
  assign ch4_auto_gain_on = state_q.agc;
  assign code_b = state_q.gain;
  assign ch4_volume_code = state_q.vol;
  assign ch4_volume_muted = state_q.muted;

endmodule : acr_channel_cfg

// ---- bench/acr_channel_cfg_sva.sv ----
/*
  acr_channel_cfg_sva: port-level checks of the channel configuration bank.
  assumes: bound to acr_channel_cfg; one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module acr_channel_cfg_sva
  import acr_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_ack_o, // acknowledge
  input wire logic wb_err_o, // error answer
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic [3:0] ch3_gain_trim_code, // gain trim
  input wire logic [7:0] ch3_phase_delay_code, // phase delay
  input wire logic [1:0] ch4_source_select, // source code
  input wire logic ch4_analog_active, // analog source
  input wire logic ch4_pdm_active, // pdm source
  input wire logic coupling_a, // dc coupling
  input wire logic [1:0] ch4_impedance_select, // impedance code
  input wire logic ch4_impedance_valid, // impedance defined
  input wire logic [5:0] code_b, // channel gain
  input wire logic [7:0] ch4_volume_code, // volume
  input wire logic ch4_volume_muted // mute flag
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // bus answers: one cycle later, exactly one kind; ack one cycle long
  AST_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o ^ wb_err_o) else $error("request not answered");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  // register state and its decoded outputs
  AST_RESET_VALUES: assert property ($fell(sys_rst) |-> ch3_gain_trim_code == 4'h8
    && ch3_phase_delay_code == 8'h00 && ch4_volume_code == 8'hC9)
    else $error("bad reset value");
  AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_PHASE_HOLD: assert property ($changed(ch3_phase_delay_code) |-> $past(wb_ack_o))
    else $error("phase changed without write");
  AST_SRC_DECODE: assert property (ch4_analog_active == !ch4_source_select[1]
    && ch4_pdm_active == (ch4_source_select == 2'h2)) else $error("source decode");
  AST_COUPLING: assert property (coupling_a |-> ch4_analog_active)
    else $error("coupling without analog");
  AST_IMPEDANCE: assert property (ch4_impedance_valid ==
    (ch4_analog_active && ch4_impedance_select != 2'h3)) else $error("impedance decode");
  AST_GAIN_CLAMP: assert property (code_b <= ACR_CHAN_GAIN_MAX)
    else $error("gain above range");
  AST_MUTE: assert property (ch4_volume_muted == (ch4_volume_code == 8'h00))
    else $error("mute decode");
  // main scenarios reached
  COV_ACK: cover property (wb_ack_o);
  COV_ERR: cover property (wb_err_o);
  COV_PDM: cover property (ch4_pdm_active);
endmodule : acr_channel_cfg_sva

// ---- bench/acr_channel_cfg_test.sv ----
/*
  acr_channel_cfg_test: self-checking bench for the channel configuration bank.
  assumes: acr_pkg compiled first; wishbone answer in the cycle after a take.
*/
`timescale 1ns/1ps
module acr_channel_cfg_test import acr_pkg::*;;
  logic clock = 1'h0, sys_rst = 1'h1, wb_cyc_i = 1'h0, wb_we_i = 1'h0, wb_stb_i;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'hF, sel_next = 4'hF, ch3_gain_trim_code;
  logic wb_ack_o, wb_err_o, ch4_line_select, ch4_analog_active, ch4_pdm_active;
  logic coupling_a, ch4_impedance_valid, ch4_auto_gain_on, ch4_volume_muted;
  logic [7:0] ch3_phase_delay_code, ch4_volume_code;
  logic [1:0] ch4_source_select, ch4_impedance_select;
  logic [5:0] code_b;
  int errors = 0, n_compared = 0, cycles = 0;
  // strobe follows cycle: classic single transfers only
  assign wb_stb_i = wb_cyc_i;
  acr_channel_cfg uut (.*);
  initial forever #5 clock = ~clock;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one transfer; ack and read data are taken at the rising edge that samples ack high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
    input logic [7:0] x, input logic xerr);
    int n;
    logic [31:0] r;
    logic e, a;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'h1;
    wb_we_i <= w;
    wb_sel_i <= sel_next;
    wb_adr_i <= {22'h0, idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    do @(posedge clock); while (!(wb_ack_o || wb_err_o) && ++n < 20);
    r = wb_dat_o;
    e = wb_err_o;
    a = wb_ack_o || wb_err_o;
    wb_cyc_i <= 1'h0;
    // derived outputs lag the stored register by one cycle; look once settled
    @(negedge clock);
    chk("answer", 8'h1, 8'(a));
    chk("err", 8'(xerr), 8'(e));
    if (!w)
      chk("rdata", x, r[7:0]);
  endtask : bus

  task automatic t_reset();
    bus(1'h0, 8'h49, 8'h00, 8'h80, 1'h0);
    bus(1'h0, 8'h4A, 8'h00, 8'h00, 1'h0);
    bus(1'h0, 8'h4B, 8'h00, 8'h00, 1'h0);
    bus(1'h0, 8'h4C, 8'h00, 8'h00, 1'h0);
    bus(1'h0, 8'h4D, 8'h00, 8'hC9, 1'h0);
  endtask : t_reset

  task automatic t_trim();
    bus(1'h1, 8'h49, 8'hFF, 8'h00, 1'h0);
    bus(1'h0, 8'h49, 8'h00, 8'hF0, 1'h0);
    chk("trim", 8'h0F, 8'(ch3_gain_trim_code));
    sel_next = 4'hE;
    bus(1'h1, 8'h49, 8'h00, 8'h00, 1'h0);
    sel_next = 4'hF;
    chk("trim", 8'h0F, 8'(ch3_gain_trim_code));
    bus(1'h1, 8'h4A, 8'hFF, 8'h00, 1'h0);
    chk("phase", 8'hFF, ch3_phase_delay_code);
  endtask : t_trim

  // every source code, with impedance codes walked alongside
  task automatic t_setup();
    logic [1:0] c;
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      c = i[1:0];
      d = {1'h1, c, 1'h1, c, 2'h3};
      // no shared pins exist here, so pin muxing is taken as already set up
      bus(1'h1, 8'h4B, d, 8'h00, 1'h0);
      bus(1'h0, 8'h4B, 8'h00, d & 8'hFD, 1'h0);
      chk("line", 8'h1, 8'(ch4_line_select));
      chk("analog", 8'(!c[1]), 8'(ch4_analog_active));
      chk("pdm", 8'(c == 2'h2), 8'(ch4_pdm_active));
      chk("coupling", 8'(!c[1]), 8'(coupling_a));
      chk("impvalid", 8'(!c[1]), 8'(ch4_impedance_valid));
      chk("agc", 8'h0, 8'(ch4_auto_gain_on));
    end
    bus(1'h1, 8'h4B, 8'h0D, 8'h00, 1'h0);
    chk("impvalid", 8'h0, 8'(ch4_impedance_valid));
    bus(1'h1, 8'h6C, 8'hFF, 8'h00, 1'h0);
    bus(1'h0, 8'h6C, 8'h00, 8'h08, 1'h0);
    chk("agc", 8'h1, 8'(ch4_auto_gain_on));
  endtask : t_setup

  task automatic t_gain();
    logic [5:0] g [4];
    g = '{6'h00, 6'h2A, 6'h2B, 6'h3F};
    foreach (g[i])
    begin
      bus(1'h1, 8'h4C, {g[i], 2'h3}, 8'h00, 1'h0);
      bus(1'h0, 8'h4C, 8'h00, {g[i], 2'h0}, 1'h0);
      chk("gain", 8'((g[i] > 6'h2A) ? 6'h2A : g[i]), 8'(code_b));
    end
  endtask : t_gain

  // volume ends at full scale so the status read below is predictable
  task automatic t_vol_err();
    bus(1'h1, 8'h4D, 8'h00, 8'h00, 1'h0);
    chk("muted", 8'h1, 8'(ch4_volume_muted));
    bus(1'h1, 8'h4D, 8'hFF, 8'h00, 1'h0);
    chk("muted", 8'h0, 8'(ch4_volume_muted));
    chk("volume", 8'hFF, ch4_volume_code);
    bus(1'h0, 8'h50, 8'h00, 8'h00, 1'h1);
    bus(1'h1, 8'h70, 8'hFF, 8'h00, 1'h0);
    bus(1'h0, 8'h70, 8'h00, 8'h44, 1'h0);
  endtask : t_vol_err

  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // hang guard, far above the roughly 110 cycles the run needs
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      errors++;
      conclude();
    end
  end

  initial
  begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'h0;
    t_reset();
    t_trim();
    t_setup();
    t_gain();
    t_vol_err();
    conclude();
  end
endmodule : acr_channel_cfg_test

bind acr_channel_cfg acr_channel_cfg_sva chk_i (.*);
